// >>> crs_board.sv
module crs_board (
    input wire clk,
    output logic rst_n = 1'b1,
    output logic irq = 1'b0,
    output logic tms = 1'b1,
    output logic tck = 1'b0
);
    timeunit 1ns / 1ps;
    // six slow rising test clocks with mode held high, clock still afterwards
    task automatic tap_reset();
        repeat (12) begin
            repeat (4) @(posedge clk);
            tck <= ~tck;
        end
        repeat (4) @(posedge clk);
        tms <= 1'b0;
    endtask
    // one test clock with mode low takes the controller out of its cleared state
    task automatic tap_idle();
        repeat (2) begin
            repeat (4) @(posedge clk);
            tck <= ~tck;
        end
    endtask
    // chip reset pressed while the core clock keeps running
    task automatic press(input logic int_zero);
        @(posedge clk);
        irq <= int_zero;
        rst_n <= 1'b0;
    endtask
    task automatic free();
        @(posedge clk);
        rst_n <= 1'b1;
        irq <= 1'b0;
    endtask
endmodule // crs_board

// >>> crs_chip_reset_seq.v
`include "crs_defines.vh"

// Operation
// - powerup circuit clears the test-port controller without any outside action; TAP_RESET is set while RESET is high and by six rising test clocks with mode high.
// - reset with interrupt line zero tristates all outputs except test data out.
// - reset alone holds memory, peripheral, select and write strobes high; clock runs.
// - grades above 50 MIPS use the PLL, never the direct input clock.
// - clock output half period equals internal clock period, direct or PLL derived.
// - slow clock select gives clock output period between 0.74 and 1.6 us.
// - fully static logic keeps state for any input clock period.
module crs_chip_reset_seq #(
    parameter SPEED_MIPS = 40,
    parameter SLOW_HALF = `CRS_SLOW_HALF_CYCLES
) (
    input wire CORE_CLK,
    input wire RESET,
    input wire CHIP_RESET_N,
    input wire INTERRUPT_LINE_ZERO,
    input wire TMS,
    input wire TCK,
    input wire SLOW_CLOCK_SELECT,
    input wire PLL_SELECT,
    input wire [`CRS_PLL_M_W-1:0] PLL_M,
    input wire [`CRS_PLL_N_W-1:0] PLL_N,
    input wire EXT_ROM_ENABLE_CORE,
    input wire EXT_RAM_HIGH_ENABLE_CORE,
    input wire EXT_RAM_LOW_ENABLE_CORE,
    input wire IO_ENABLE_CORE,
    input wire DEVICE_SELECT_CORE,
    input wire WRITE_STROBE_N_CORE,
    output reg CLOCK_OUTPUT,
    output reg EXT_ROM_ENABLE,
    output reg EXT_RAM_HIGH_ENABLE,
    output reg EXT_RAM_LOW_ENABLE,
    output reg IO_ENABLE,
    output reg DEVICE_SELECT_OUT,
    output reg WRITE_STROBE_N,
    output reg PINS_OE,
    output reg CORE_RESET,
    output reg TAP_RESET,
    output reg PLL_IN_USE
);
    localparam ST_POWERUP = 2'b00;
    localparam ST_RESET = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam integer RST_MIN_I = `CRS_RESET_MIN_PERIODS;
    localparam integer TAP_EDGES_I = `CRS_TAP_RESET_EDGES;
    localparam integer SLOW_HALF_I = SLOW_HALF;
    localparam [2:0] RST_MIN = RST_MIN_I[2:0];
    localparam [2:0] TAP_EDGES = TAP_EDGES_I[2:0];
    localparam [10:0] SLOW_HALF_W = SLOW_HALF_I[10:0];

    // three-stage pin synchronisers
    reg [2:0] rst_s;
    reg [2:0] int_s;
    reg [2:0] tms_s;
    reg [2:0] tck_s;
    reg [2:0] slow_s;
    reg rst_n_q;
    reg int_q;
    reg tck_q;
    reg tms_q;
    reg slow_q;
    reg [1:0] state;
    reg [2:0] low_cnt;
    reg [2:0] tap_cnt;
    reg [10:0] div_cnt;
    reg [`CRS_PLL_N_W:0] pll_cnt;
    wire use_pll;
    wire tick;

    // filtered copy: change counts once stages two and three agree
    function agree;
        input [2:0] s;
        input old;
        begin
            agree = (s[1] == s[2]) ? s[2] : old;
        end
    endfunction

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            rst_s <= 3'h0;
            int_s <= 3'h0;
            tms_s <= 3'h7;
            tck_s <= 3'h0;
            slow_s <= 3'h0;
            rst_n_q <= 1'b0;
            int_q <= 1'b0;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            slow_q <= 1'b0;
        end else begin
            rst_s <= {rst_s[1:0], CHIP_RESET_N};
            int_s <= {int_s[1:0], INTERRUPT_LINE_ZERO};
            tms_s <= {tms_s[1:0], TMS};
            tck_s <= {tck_s[1:0], TCK};
            slow_s <= {slow_s[1:0], SLOW_CLOCK_SELECT};
            rst_n_q <= agree(rst_s, rst_n_q);
            int_q <= agree(int_s, int_q);
            tck_q <= agree(tck_s, tck_q);
            tms_q <= agree(tms_s, tms_q);
            slow_q <= agree(slow_s, slow_q);
        end
    end

    // fast grades are forced onto the pll
    assign use_pll = PLL_SELECT || (SPEED_MIPS > `CRS_DIRECT_MAX_MIPS);

    // internal clock tick: every cycle direct, or every N+1 cycles via pll ratio
    assign tick = !use_pll || (pll_cnt == 0);

    // clock output divider, restarted by reset for a known phase
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            pll_cnt <= {(`CRS_PLL_N_W + 1){1'b0}};
            div_cnt <= 11'h000;
            CLOCK_OUTPUT <= 1'b0;
        end else begin
            if (!use_pll || pll_cnt >= {1'b0, PLL_N}) begin
                pll_cnt <= {(`CRS_PLL_N_W + 1){1'b0}};
            end else begin
                pll_cnt <= pll_cnt + 1'b1;
            end
            // phase restart only at reset entry, never while the pin is released
            if (state == ST_RESET && low_cnt == 3'h0 && !rst_n_q) begin
                div_cnt <= 11'h000;
                CLOCK_OUTPUT <= 1'b0;
            end else if (slow_q) begin
                if (div_cnt >= SLOW_HALF_W - 11'h001) begin
                    div_cnt <= 11'h000;
                    CLOCK_OUTPUT <= ~CLOCK_OUTPUT;
                end else begin
                    div_cnt <= div_cnt + 11'h001;
                end
            end else if (tick) begin
                CLOCK_OUTPUT <= ~CLOCK_OUTPUT;
                div_cnt <= 11'h000;
            end
        end
    end

    // reset sequencing and test-port clearing
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            state <= ST_POWERUP;
            low_cnt <= 3'h0;
            tap_cnt <= 3'h0;
            TAP_RESET <= 1'b1;
            CORE_RESET <= 1'b1;
            PLL_IN_USE <= 1'b0;
        end else begin
            PLL_IN_USE <= use_pll;
            // six rising test clocks with mode high clear the controller
            if (agree(tck_s, tck_q) && !tck_q) begin
                if (tms_q) begin
                    if (tap_cnt == TAP_EDGES - 3'h1) begin
                        TAP_RESET <= 1'b1;
                        tap_cnt <= 3'h0;
                    end else begin
                        tap_cnt <= tap_cnt + 3'h1;
                    end
                end else begin
                    tap_cnt <= 3'h0;
                    TAP_RESET <= 1'b0;
                end
            end else if (state == ST_POWERUP) begin
                TAP_RESET <= 1'b0;
            end
            case (state)
                ST_POWERUP: begin
                    state <= rst_n_q ? ST_RUN : ST_RESET;
                    CORE_RESET <= 1'b1;
                end
                ST_RESET: begin
                    CORE_RESET <= 1'b1;
                    if (!rst_n_q) begin
                        if (tick && low_cnt != RST_MIN) begin
                            low_cnt <= low_cnt + 3'h1;
                        end
                    end else if (low_cnt == RST_MIN) begin
                        state <= ST_RUN;
                        CORE_RESET <= 1'b0;
                    end else begin
                        low_cnt <= 3'h0; // short pulse: count restarts, core stays in reset
                    end
                end
                ST_RUN: begin
                    CORE_RESET <= 1'b0;
                    if (!rst_n_q) begin
                        state <= ST_RESET;
                        low_cnt <= 3'h0;
                        CORE_RESET <= 1'b1;
                    end
                end
                default: state <= ST_POWERUP;
            endcase
        end
    end

    // pin states under reset; state kept with no time limit
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            EXT_ROM_ENABLE <= 1'b1;
            EXT_RAM_HIGH_ENABLE <= 1'b1;
            EXT_RAM_LOW_ENABLE <= 1'b1;
            IO_ENABLE <= 1'b1;
            DEVICE_SELECT_OUT <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            PINS_OE <= 1'b1;
        end else if (!rst_n_q || state != ST_RUN) begin
            // interrupt zero with chip reset floats pins; levels parked high
            PINS_OE <= rst_n_q || !int_q;
            EXT_ROM_ENABLE <= 1'b1;
            EXT_RAM_HIGH_ENABLE <= 1'b1;
            EXT_RAM_LOW_ENABLE <= 1'b1;
            IO_ENABLE <= 1'b1;
            DEVICE_SELECT_OUT <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
        end else begin
            PINS_OE <= 1'b1;
            EXT_ROM_ENABLE <= EXT_ROM_ENABLE_CORE;
            EXT_RAM_HIGH_ENABLE <= EXT_RAM_HIGH_ENABLE_CORE;
            EXT_RAM_LOW_ENABLE <= EXT_RAM_LOW_ENABLE_CORE;
            IO_ENABLE <= IO_ENABLE_CORE;
            DEVICE_SELECT_OUT <= DEVICE_SELECT_CORE;
            WRITE_STROBE_N <= WRITE_STROBE_N_CORE;
        end
    end
endmodule // crs_chip_reset_seq

// >>> crs_defines.vh
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// core clock period in picoseconds (40 MHz)
`define CRS_CLK_PERIOD_PS 25000
// slow clock output period bounds, nanoseconds
`define CRS_SLOW_MIN_NS 740
`define CRS_SLOW_MAX_NS 1600
// slow half period in core cycles: midpoint 1170 ns / 25 ns / 2, rounded down
`define CRS_SLOW_HALF_CYCLES ((((`CRS_SLOW_MIN_NS + `CRS_SLOW_MAX_NS) / 2) * 1000) / (2 * `CRS_CLK_PERIOD_PS))
// least chip reset pulse in internal clock periods
`define CRS_RESET_MIN_PERIODS 6
// test-port reset edge count
`define CRS_TAP_RESET_EDGES 6
// speed limit for direct clock, MIPS
`define CRS_DIRECT_MAX_MIPS 50
// pll ratio field widths
`define CRS_PLL_M_W 5
`define CRS_PLL_N_W 4
`endif

// >>> crs_props.sv
module crs_props #(
    parameter SPEED_MIPS = 40
) (
    input wire CORE_CLK,
    input wire RESET,
    input wire CHIP_RESET_N,
    input wire INTERRUPT_LINE_ZERO,
    input wire SLOW_CLOCK_SELECT,
    input wire PLL_SELECT,
    input wire CLOCK_OUTPUT,
    input wire EXT_ROM_ENABLE,
    input wire WRITE_STROBE_N,
    input wire PINS_OE,
    input wire CORE_RESET,
    input wire TAP_RESET,
    input wire PLL_IN_USE
);
    timeunit 1ns / 1ps;
    // pin request conditions
    wire held = !CHIP_RESET_N && !INTERRUPT_LINE_ZERO;
    wire off_req = !CHIP_RESET_N && INTERRUPT_LINE_ZERO;
    wire fast = CHIP_RESET_N && !SLOW_CLOCK_SELECT && !PLL_SELECT;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // pin states during reset, clock output timing, test-port clear, clock source and core reset release
    a_tap_cleared: assert property (disable iff (1'b0) RESET |=> TAP_RESET)
        else $error("test controller not cleared");
    a_pins_float: assert property (off_req [*8] |-> !PINS_OE)
        else $error("pins still driven");
    a_strobes_high: assert property (held [*8] |-> PINS_OE && EXT_ROM_ENABLE && WRITE_STROBE_N)
        else $error("strobes not held high");
    a_clock_runs: assert property (held [*8] |-> ##[1:32] $changed(CLOCK_OUTPUT))
        else $error("clock output stopped in reset");
    a_pll_forced: assert property (!PLL_SELECT [*3] |-> PLL_IN_USE == (SPEED_MIPS > 50))
        else $error("clock source wrong for speed");
    a_fast_clock: assert property (fast [*4] |-> $changed(CLOCK_OUTPUT))
        else $error("clock output slower than internal clock");
    a_slow_range: assert property (SLOW_CLOCK_SELECT [*8] ##0 $changed(CLOCK_OUTPUT) |=>
        $stable(CLOCK_OUTPUT) [*8] ##[7:24] $changed(CLOCK_OUTPUT)) else $error("slow period out of range");
    a_release_sync: assert property ($fell(CORE_RESET) |-> CHIP_RESET_N && $past(CHIP_RESET_N, 3))
        else $error("core reset released early");
endmodule // crs_props
bind crs_chip_reset_seq crs_props #(.SPEED_MIPS(SPEED_MIPS)) u_props (.CORE_CLK, .RESET,
    .CHIP_RESET_N, .INTERRUPT_LINE_ZERO, .SLOW_CLOCK_SELECT, .PLL_SELECT, .CLOCK_OUTPUT,
    .EXT_ROM_ENABLE, .WRITE_STROBE_N, .PINS_OE, .CORE_RESET, .TAP_RESET, .PLL_IN_USE);

// >>> tb.sv
module tb;
    timeunit 1ns / 1ps;
    logic clk = 1'b0, reset = 1'b1, slow = 1'b0, pll = 1'b0, sample = 1'b0, last = 1'b0;
    logic [4:0] pll_m = 5'h00;
    logic [3:0] pll_n = 4'h0;
    logic [5:0] core = 6'h00;
    logic [7:0] hp = 8'h00, cnt = 8'h00;
    logic [8:0] q[$];
    wire rst_n, irq, tms, tck, clk_out, oe, core_rst, tap_rst;
    wire [5:0] pin;
    int n_errors = 0, compares = 0, i, n, k;
    // 40 MHz core clock
    always #12.5 clk = ~clk;
    crs_board brd (.clk(clk), .rst_n(rst_n), .irq(irq), .tms(tms), .tck(tck));
    crs_chip_reset_seq #(.SLOW_HALF(20)) uut (.CORE_CLK(clk), .RESET(reset),
        .CHIP_RESET_N(rst_n), .INTERRUPT_LINE_ZERO(irq), .TMS(tms), .TCK(tck),
        .SLOW_CLOCK_SELECT(slow), .PLL_SELECT(pll), .PLL_M(pll_m), .PLL_N(pll_n),
        .EXT_ROM_ENABLE_CORE(core[5]), .EXT_RAM_HIGH_ENABLE_CORE(core[4]),
        .EXT_RAM_LOW_ENABLE_CORE(core[3]), .IO_ENABLE_CORE(core[2]),
        .DEVICE_SELECT_CORE(core[1]), .WRITE_STROBE_N_CORE(core[0]), .CLOCK_OUTPUT(clk_out),
        .EXT_ROM_ENABLE(pin[5]), .EXT_RAM_HIGH_ENABLE(pin[4]), .EXT_RAM_LOW_ENABLE(pin[3]),
        .IO_ENABLE(pin[2]), .DEVICE_SELECT_OUT(pin[1]), .WRITE_STROBE_N(pin[0]),
        .PINS_OE(oe), .CORE_RESET(core_rst), .TAP_RESET(tap_rst), .PLL_IN_USE());
    task automatic cmp_pins(input logic [7:0] e);
        compares++;
        if ({tap_rst, oe, pin} !== e) begin
            n_errors++;
            $display("wrong value pins expected %h seen %h", e, {tap_rst, oe, pin});
        end
    endtask
    task automatic cmp_half(input logic [7:0] e);
        compares++;
        if (hp !== e) begin
            n_errors++;
            $display("wrong value half period expected %h seen %h", e, hp);
        end
    endtask
    // half period meter and scoreboard against the oldest note
    always @(posedge clk) begin
        last <= clk_out;
        cnt <= (clk_out !== last) ? 8'h01 : cnt + 8'h01;
        if (clk_out !== last) hp <= cnt;
        if (sample === 1'b1 && q.size() > 0) begin
            if (q[0][8]) cmp_half(q[0][7:0]);
            else cmp_pins(q[0][7:0]);
            void'(q.pop_front());
        end
    end
    task automatic note(input logic kind, input logic [7:0] v);
        q.push_back({kind, v});
        sample <= 1'b1;
        @(posedge clk);
        sample <= 1'b0;
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // reset, tap clear, both chip reset pin cases, then clock output modes
    initial begin
        void'($urandom(32'h5B14));
        repeat (19) @(posedge clk);
        note(1'b0, 8'hFF);
        reset <= 1'b0;
        brd.tap_reset();
        note(1'b0, 8'hFF);
        brd.tap_idle();
        for (i = 0; i < 2; i++) begin
            core <= 6'($urandom);
            brd.press(i[0]);
            repeat (10) @(posedge clk);
            note(1'b0, {1'b0, ~i[0], 6'h3F});
            brd.free();
            for (k = 0; k < 60 && core_rst !== 1'b0; k++) @(posedge clk);
            if (core_rst !== 1'b0) begin
                n_errors++;
                end_sim();
            end
            repeat (4) @(posedge clk);
            note(1'b0, {2'b01, core});
        end
        for (i = 0; i < 3; i++) begin
            n = $urandom_range(15);
            slow <= (i == 2);
            pll <= (i == 1);
            pll_n <= 4'(n);
            pll_m <= 5'($urandom);
            repeat (80) @(posedge clk);
            note(1'b1, (i == 0) ? 8'h01 : (i == 1) ? 8'(n + 1) : 8'h14);
        end
        end_sim();
    end
endmodule // tb
